// ### tb.sv
// Self-checking bench of the flow control block
`timescale 1ns/1ps
module tb;
    int seed = 47, num_errors = 0, checks_done = 0, hits = 0;
    logic clk_sys = 0, srst = 1, reg_wr = 0, reg_rd = 0, buf_ready = 0, hold_buf = 0;
    logic special_detect_enable = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, rx_fifo_level = 0;
    logic [3:0] gpio_in = 0;
    logic [7:0] reg_rdata, rx_data, buf_data, fc_tx_data, r1, r2, h1, h2, cur;
    logic rx_valid, rx_ready, buf_valid, fc_tx_valid, fc_tx_ready, cts_n, rts_n, tx_stop;
    logic special_hit;
    logic [7:0] ch[4], drained[$], want[$]; // want: bytes expected out
    bit ok;
    always #25 clk_sys = ~clk_sys;
    ufc_top dut (.*);
    ufc_remote_model remote (.*);
    // Drain side with random stalls, and pulse counting
    always @(posedge clk_sys) begin
        if (buf_valid && buf_ready) drained.push_back(buf_data);
        if (special_hit === 1'b1) hits++;
        buf_ready <= !hold_buf && ($random(seed) % 3) != 0;
    end
    // Expected flow character i for a transmit select pair
    function automatic logic [7:0] flow_exp(input logic [1:0] s, input int i);
        case (s)
            2'b10: return i == 0 ? h1 : r1;
            2'b01: return i == 0 ? h2 : r2;
            default: return i == 0 ? h1 : i == 1 ? h2 : i == 2 ? r1 : r2;
        endcase
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        tick(1);
        reg_wr <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        reg_rd <= 1'b1;
        reg_addr <= a;
        tick(1);
        reg_rd <= 1'b0;
        tick(1);
        chk(what, exp, reg_rdata);
    endtask
    task automatic put(input logic [7:0] b, input bit keep);
        remote.send(b, 40, ok);
        if (keep) want.push_back(b);
        if (!ok) begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    // One received byte under a mode, then stop level and pulse count
    task automatic step(input logic [7:0] c, input logic d, input logic [7:0] b, input bit keep,
        input bit stop, input int hit);
        int h0;
        if (c !== cur) wr(8'h13, c);
        cur = c;
        special_detect_enable <= d;
        h0 = hits;
        put(b, keep);
        remote.idle();
        tick(4);
        chk("tx stop", 8'(stop), 8'(tx_stop));
        chk("hit count", 8'(hit), 8'(hits - h0));
    endtask
    task automatic drain();
        hold_buf <= 1'b0;
        for (int n = 0; n < 300 && drained.size() < want.size(); n++) tick(1);
        chk("drained count", 8'(want.size()), 8'(drained.size()));
    endtask
    task automatic wait_got(input int n);
        for (int i = 0; i < 100 && remote.got.size() < n; i++) tick(1);
        chk("flow count", 8'(n), 8'(remote.got.size()));
    endtask
    initial begin
        r1 = {4'($random(seed)), 4'h1};
        r2 = {4'($random(seed)), 4'h2};
        h1 = {4'($random(seed)), 4'h3};
        h2 = {4'($random(seed)), 4'h4};
        ch = '{r1, r2, h1, h2};
        cur = 8'h00;
        tick(8);
        srst <= 1'b0;
        tick(1);
        rd(8'h02, 8'h80, "cts flag at start");
        for (int a = 8'h13; a < 8'h18; a++) rd(8'(a), 8'h00, "reset value");
        rd(8'h3c, 8'h00, "unmapped");
        foreach (ch[i]) wr(8'h14 + 8'(i), ch[i]);
        foreach (ch[i]) rd(8'h14 + 8'(i), ch[i], "char register");
        gpio_in <= {1'b1, 3'($random(seed))};
        wr(8'h13, 8'h14);
        cur = 8'h14;
        rd(8'h17, h2, "halt two stored");
        step(8'h14, 1, {h2[7:4], gpio_in}, 1, 0, 1);
        step(8'h14, 1, h2, 1, 0, 0);
        step(8'h14, 1, r2, 1, 0, 1);
        step(8'h20, 1, h1, 1, 0, 1);
        step(8'h00, 1, h1, 1, 0, 0);
        step(8'h28, 0, h1, 0, 1, 0);
        step(8'h28, 0, 8'h59, 1, 1, 0);
        step(8'h28, 0, r1, 0, 0, 0);
        step(8'h38, 1, h2, 1, 0, 1);
        step(8'h38, 1, h1, 0, 1, 0);
        step(8'h38, 1, r1, 0, 0, 0);
        step(8'h38, 0, h1, 0, 0, 0);
        step(8'h38, 0, h2, 0, 1, 0);
        step(8'h38, 0, r1, 1, 1, 0);
        step(8'h38, 0, 8'h69, 1, 1, 0);
        step(8'h38, 0, r1, 0, 1, 0);
        step(8'h38, 0, r2, 0, 0, 0);
        drain();
        // Fill the buffer with the drain stalled until it refuses
        wr(8'h13, 8'h00);
        hold_buf <= 1'b1;
        tick(2);
        repeat (9) put(8'($random(seed)), 1'b1);
        remote.send(8'h5a, 6, ok);
        chk("full refusal", 0, 8'(ok));
        hold_buf <= 1'b0;
        put(8'h5a, 1'b1);
        remote.idle();
        drain();
        foreach (want[i]) chk("drained byte", want[i], drained[i]);
        wr(8'h0f, 8'h25);
        for (int s = 1; s <= 3; s++) begin
            rx_fifo_level <= 8'd39;
            wr(8'h13, {2'(s), 6'h08});
            tick(6);
            chk("below halt", 0, 8'(remote.got.size()));
            rx_fifo_level <= 8'd40;
            wait_got(s == 3 ? 2 : 1);
            rx_fifo_level <= 8'd16;
            wait_got(s == 3 ? 4 : 2);
            foreach (remote.got[i]) chk("flow char", flow_exp(2'(s), i), remote.got[i]);
            remote.got.delete();
        end
        // Auto request-to-send hysteresis, then auto clear-to-send stop and CTS change flag
        wr(8'h13, 8'h03);
        rx_fifo_level <= 8'd40;
        tick(3);
        chk("rts at halt", 1, 8'(rts_n));
        rx_fifo_level <= 8'd17;
        tick(3);
        chk("rts held", 1, 8'(rts_n));
        rx_fifo_level <= 8'd16;
        tick(3);
        chk("rts at resume", 0, 8'(rts_n));
        remote.cts_n <= 1'b1;
        tick(3);
        chk("cts stop", 1, 8'(tx_stop));
        rd(8'h02, 8'h80, "cts flag set");
        rd(8'h02, 8'h00, "cts flag cleared");
        remote.cts_n <= 1'b0;
        tick(3);
        chk("cts go", 0, 8'(tx_stop));
        rd(8'h02, 8'h80, "cts flag again");
        tally_and_finish();
    end
endmodule

// ### ufc_defs.svh
// Register offsets, field positions, reset values and level constants of the flow block
`ifndef UFC_DEFS_SVH
`define UFC_DEFS_SVH

// Register offsets
`define UFC_ADDR_STATUS 8'h02
`define UFC_ADDR_FLOW_LEVEL 8'h0f
`define UFC_ADDR_RX_LEVEL 8'h12
`define UFC_ADDR_FLOW_CFG 8'h13
`define UFC_ADDR_RESUME_ONE 8'h14
`define UFC_ADDR_RESUME_TWO 8'h15
`define UFC_ADDR_HALT_ONE 8'h16
`define UFC_ADDR_HALT_TWO 8'h17

// Reset values
`define UFC_RST_BYTE 8'h00

// Flow control register fields
`define UFC_TX_SET1_BIT 7
`define UFC_TX_SET2_BIT 6
`define UFC_RX_SET1_BIT 5
`define UFC_RX_SET2_BIT 4
`define UFC_SOFT_EN_BIT 3
`define UFC_PIN_ADDR_BIT 2
`define UFC_AUTO_CTS_BIT 1
`define UFC_AUTO_RTS_BIT 0

// Status register field
`define UFC_CTS_FLAG_BIT 7

// Flow level register fields and threshold step
`define UFC_RESUME_MSB 7
`define UFC_RESUME_LSB 4
`define UFC_HALT_MSB 3
`define UFC_HALT_LSB 0
`define UFC_THR_SHIFT 3

// Staging buffer size
`define UFC_BUF_WIDTH 8
`define UFC_BUF_DEPTH 8

`endif

// ### ufc_fifo.sv
// Parameterised FIFO with a registered output word
`timescale 1ns/1ps
module ufc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic srst,
    ufc_stream_if.sink wr,
    ufc_stream_if.source rd,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH]; // Storage words
    logic [AW-1:0] wp; // Write pointer
    logic [AW-1:0] rp; // Read pointer
    logic [CW-1:0] cnt; // Words held in storage
    logic out_valid; // Output register holds a word
    logic [WIDTH-1:0] out_data; // Output register
    logic push; // Word taken in
    logic load; // Word moved to the output register

    assign wr.ready = (cnt != FULL);
    assign push = wr.valid && wr.ready;
    assign load = (cnt != '0) && (!out_valid || rd.ready);
    assign rd.valid = out_valid;
    assign rd.data = out_data;
    assign level = cnt + CW'(out_valid);

    // Storage write
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wp] <= wr.data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
            end
            if (load) begin
                rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
            end
            cnt <= cnt + CW'(push) - CW'(load);
        end
    end

    // Output register, refilled when empty or drained
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (load) begin
            out_valid <= 1'b1;
            out_data <= mem[rp];
        end else if (rd.ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule

// ### ufc_pkg.sv
// Types shared by the flow control block
package ufc_pkg;

    // Receive pairing states, Gray coded
    typedef enum logic [1:0] {
        UFC_RX_IDLE = 2'b00,
        UFC_RX_RESUME_LO = 2'b01,
        UFC_RX_HALT_LO = 2'b11
    } ufc_rx_state_t;

    // Transmit flow character states, Gray coded
    typedef enum logic [1:0] {
        UFC_TX_IDLE = 2'b00,
        UFC_TX_FIRST = 2'b01,
        UFC_TX_SECOND = 2'b11
    } ufc_tx_state_t;

endpackage

// ### ufc_remote_model.sv
// Remote station model: offers received bytes, takes flow characters, drives CTS
`timescale 1ns/1ps
module ufc_remote_model (
    input logic clk_sys,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input logic rx_ready,
    input logic fc_tx_valid,
    input logic [7:0] fc_tx_data,
    output logic fc_tx_ready,
    output logic cts_n
);
    int seed = 47; // Fixed seed for stalls
    logic [7:0] got[$]; // Flow characters received in order
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        fc_tx_ready = 1'b0;
        cts_n = 1'b0;
    end
    // Take flow characters, stalling at random
    always @(posedge clk_sys) begin
        if (fc_tx_valid && fc_tx_ready) got.push_back(fc_tx_data);
        fc_tx_ready <= ($random(seed) % 3) != 0;
    end
    // Offer one byte and hold it until taken or the bound runs out
    task automatic send(input logic [7:0] b, input int lim, output bit ok);
        ok = 1'b0;
        rx_valid <= 1'b1;
        rx_data <= b;
        for (int n = 0; n < lim && !ok; n++) begin
            @(negedge clk_sys);
            ok = rx_ready;
            @(posedge clk_sys);
        end
    endtask
    // Release the line; data shows the inverse of the last byte
    task automatic idle();
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
    endtask
endmodule

// ### ufc_stream_if.sv
// Valid/ready byte stream between the flow block and its staging buffer
`timescale 1ns/1ps
interface ufc_stream_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    // Producer end
    modport source (output valid, output data, input ready);
    // Consumer end
    modport sink (input valid, input data, output ready);
endinterface

// ### ufc_top.sv
// Flow control and special character logic of one UART channel
// Functional notes
// - Transmit select bits pick emitted halt/resume characters
// - Receive select bits pick compared and detected sets
// - All select bits zero disables flow characters and detection, not auto CTS/RTS
// - Matched flow characters never enter receive buffer
// - Detection only mode never pauses transmitter
// - Both on: set one flows, set two detects
// - Soft enable turns on automatic software flow
// - Pin match: halt two high nibble plus pins
// - Halt two reads back stored value always
// - Auto clear-to-send stops transmitter on high CTS
// - Any CTS change sets sticky change flag
// - Auto request-to-send follows receive level thresholds
// - Double mode: resume one is low byte
// - Double mode: resume two is high byte
// - Thresholds are eight times level fields
// - Double mode: halt one low, two high
`timescale 1ns/1ps
`include "ufc_defs.svh"
module ufc_top (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic special_detect_enable,
    input wire logic [3:0] gpio_in,
    input wire logic [7:0] rx_fifo_level,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic buf_valid,
    output logic [7:0] buf_data,
    input wire logic buf_ready,
    output logic fc_tx_valid,
    output logic [7:0] fc_tx_data,
    input wire logic fc_tx_ready,
    input wire logic cts_n,
    output logic rts_n,
    output logic tx_stop,
    output logic special_hit
);
    import ufc_pkg::*;

    logic [7:0] flow_control_config; // Flow control register
    logic [7:0] resume_char_one; // First resume character
    logic [7:0] resume_char_two; // Second resume character
    logic [7:0] halt_char_one; // First halt character
    logic [7:0] halt_char_two; // Second halt character
    logic [7:0] flow_level; // Halt and resume thresholds
    logic cts_change_flag; // Sticky CTS change flag
    logic cts_n_prev; // CTS level of the last cycle
    logic remote_halted; // Remote station asked us to halt
    logic halt_sent; // Our halt was sent, resume pending
    ufc_rx_state_t rx_state; // Receive pairing state
    ufc_rx_state_t next_rx_state;
    ufc_tx_state_t tx_state; // Transmit flow character state
    logic [7:0] held_byte; // Low byte waiting for its pair
    logic tx_is_halt; // Current emission is a halt

    // Decoded configuration
    logic soft_flow_enable;
    logic pin_address_match;
    logic auto_clear_to_send;
    logic auto_request_to_send;
    logic tx_set1;
    logic tx_set2;
    logic rx_set1;
    logic rx_set2;
    logic both_mode;
    logic rx_flow_on;
    logic rx_flow_double;
    logic [7:0] special_halt_two;
    logic [7:0] halt_thr;
    logic [7:0] resume_thr;

    // Combinational receive decisions
    logic take;
    logic push;
    logic [7:0] push_data;
    logic act_halt;
    logic act_resume;
    logic detect;
    logic cts_change;
    logic status_read;

    ufc_stream_if #(.WIDTH(`UFC_BUF_WIDTH)) buf_in ();
    ufc_stream_if #(.WIDTH(`UFC_BUF_WIDTH)) buf_out ();

    // Single-character match against the chosen sets
    function automatic logic match_set(input logic [7:0] c, input logic s1, input logic s2,
                                       input logic [7:0] a1, input logic [7:0] a2);
        match_set = (s1 && (c == a1)) || (s2 && (c == a2));
    endfunction

    assign soft_flow_enable = flow_control_config[`UFC_SOFT_EN_BIT];
    assign pin_address_match = flow_control_config[`UFC_PIN_ADDR_BIT];
    assign auto_clear_to_send = flow_control_config[`UFC_AUTO_CTS_BIT];
    assign auto_request_to_send = flow_control_config[`UFC_AUTO_RTS_BIT];
    assign tx_set1 = flow_control_config[`UFC_TX_SET1_BIT];
    assign tx_set2 = flow_control_config[`UFC_TX_SET2_BIT];
    assign rx_set1 = flow_control_config[`UFC_RX_SET1_BIT];
    assign rx_set2 = flow_control_config[`UFC_RX_SET2_BIT];
    // set one flows, set two detects
    assign both_mode = soft_flow_enable && special_detect_enable;
    assign rx_flow_on = soft_flow_enable && (rx_set1 || rx_set2);
    assign rx_flow_double = rx_flow_on && !both_mode && rx_set1 && rx_set2;
    // pins form low nibble of special character
    assign special_halt_two = pin_address_match ? {halt_char_two[7:4], gpio_in} : halt_char_two;
    // thresholds are eight times the fields
    assign halt_thr = {flow_level[`UFC_HALT_MSB:`UFC_HALT_LSB], 4'h0} >> 1;
    assign resume_thr = {flow_level[`UFC_RESUME_MSB:`UFC_RESUME_LSB], 4'h0} >> 1;

    assign cts_change = (cts_n != cts_n_prev);
    assign status_read = reg_rd && (reg_addr == `UFC_ADDR_STATUS);

    // Register writes
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            flow_control_config <= `UFC_RST_BYTE;
            resume_char_one <= `UFC_RST_BYTE;
            resume_char_two <= `UFC_RST_BYTE;
            halt_char_one <= `UFC_RST_BYTE;
            halt_char_two <= `UFC_RST_BYTE;
            flow_level <= `UFC_RST_BYTE;
        end else if (reg_wr) begin
            case (reg_addr)
                `UFC_ADDR_FLOW_CFG: flow_control_config <= reg_wdata;
                `UFC_ADDR_RESUME_ONE: resume_char_one <= reg_wdata;
                `UFC_ADDR_RESUME_TWO: resume_char_two <= reg_wdata;
                `UFC_ADDR_HALT_ONE: halt_char_one <= reg_wdata;
                `UFC_ADDR_HALT_TWO: halt_char_two <= reg_wdata;
                `UFC_ADDR_FLOW_LEVEL: flow_level <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // Registered read data, unmapped offsets read zero
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata <= `UFC_RST_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                `UFC_ADDR_STATUS: reg_rdata <= {cts_change_flag, 7'h00};
                `UFC_ADDR_FLOW_LEVEL: reg_rdata <= flow_level;
                `UFC_ADDR_RX_LEVEL: reg_rdata <= rx_fifo_level;
                `UFC_ADDR_FLOW_CFG: reg_rdata <= flow_control_config;
                `UFC_ADDR_RESUME_ONE: reg_rdata <= resume_char_one;
                `UFC_ADDR_RESUME_TWO: reg_rdata <= resume_char_two;
                `UFC_ADDR_HALT_ONE: reg_rdata <= halt_char_one;
                `UFC_ADDR_HALT_TWO: reg_rdata <= halt_char_two;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // CTS edge tracking
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cts_n_prev <= 1'b1;
        end else begin
            cts_n_prev <= cts_n;
        end
    end

    // Sticky CTS change flag, cleared by a status read, set wins
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cts_change_flag <= 1'b0;
        end else if (cts_change) begin
            cts_change_flag <= 1'b1;
        end else if (status_read) begin
            cts_change_flag <= 1'b0;
        end
    end

    // Receive classification: pairing, filtering, detection
    always_comb begin
        next_rx_state = rx_state;
        take = 1'b0;
        push = 1'b0;
        push_data = rx_data;
        act_halt = 1'b0;
        act_resume = 1'b0;
        detect = 1'b0;
        if (rx_state != UFC_RX_IDLE) begin
            if (rx_valid) begin
                if (rx_state == UFC_RX_RESUME_LO && rx_data == resume_char_two) begin
                    take = 1'b1;
                    act_resume = 1'b1;
                    next_rx_state = UFC_RX_IDLE;
                end else if (rx_state == UFC_RX_HALT_LO && rx_data == halt_char_two) begin
                    take = 1'b1;
                    act_halt = 1'b1;
                    next_rx_state = UFC_RX_IDLE;
                end else begin
                    // Broken pair: release the held byte, new byte waits
                    push = 1'b1;
                    push_data = held_byte;
                    if (buf_in.ready) begin
                        next_rx_state = UFC_RX_IDLE;
                    end
                end
            end
        end else if (rx_valid) begin
            if (rx_flow_double && rx_data == resume_char_one) begin
                take = 1'b1;
                next_rx_state = UFC_RX_RESUME_LO;
            end else if (rx_flow_double && rx_data == halt_char_one) begin
                take = 1'b1;
                next_rx_state = UFC_RX_HALT_LO;
            end else if (rx_flow_on && !rx_flow_double && match_set(rx_data,
                         rx_set1 || both_mode, rx_set2 && !both_mode,
                         resume_char_one, resume_char_two)) begin
                take = 1'b1;
                act_resume = 1'b1;
            end else if (rx_flow_on && !rx_flow_double && match_set(rx_data,
                         rx_set1 || both_mode, rx_set2 && !both_mode,
                         halt_char_one, halt_char_two)) begin
                take = 1'b1;
                act_halt = 1'b1;
            end else begin
                push = 1'b1;
                take = buf_in.ready;
                // set two detects when both on
                if (both_mode) begin
                    detect = rx_set2 && ((rx_data == resume_char_two) ||
                             (rx_data == special_halt_two));
                end else if (special_detect_enable && !soft_flow_enable) begin
                    detect = match_set(rx_data, rx_set1, rx_set2,
                                       resume_char_one, resume_char_two) ||
                             match_set(rx_data, rx_set1, rx_set2,
                                       halt_char_one, special_halt_two);
                end
            end
        end
    end

    assign rx_ready = take;
    assign buf_in.valid = push;
    assign buf_in.data = push_data;

    // Pairing state and held low byte
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rx_state <= UFC_RX_IDLE;
            held_byte <= 8'h00;
        end else begin
            rx_state <= next_rx_state;
            if (take && next_rx_state != UFC_RX_IDLE) begin
                held_byte <= rx_data;
            end
        end
    end

    // Special character pulse
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            special_hit <= 1'b0;
        end else begin
            special_hit <= detect && take;
        end
    end

    // Remote halt state from received flow characters
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            remote_halted <= 1'b0;
        // no flow control with field off
        end else if (!rx_flow_on) begin
            remote_halted <= 1'b0;
        end else if (act_halt) begin
            remote_halted <= 1'b1;
        end else if (act_resume) begin
            remote_halted <= 1'b0;
        end
    end

    // Transmitter stop: software halt or CTS high under auto CTS
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tx_stop <= 1'b0;
        end else begin
            // host turns transmitter off before enabling
            tx_stop <= remote_halted || (auto_clear_to_send && cts_n);
        end
    end

    // Request-to-send from receive level with hysteresis
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rts_n <= 1'b1;
        end else if (!auto_request_to_send) begin
            rts_n <= 1'b1;
        end else if (rx_fifo_level >= halt_thr) begin
            rts_n <= 1'b1;
        end else if (rx_fifo_level <= resume_thr) begin
            rts_n <= 1'b0;
        end
    end

    // Emission of halt and resume characters
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tx_state <= UFC_TX_IDLE;
            halt_sent <= 1'b0;
            tx_is_halt <= 1'b0;
            fc_tx_valid <= 1'b0;
            fc_tx_data <= 8'h00;
        end else begin
            case (tx_state)
                UFC_TX_IDLE: begin
                    fc_tx_valid <= 1'b0;
                    // emission only with transmit bits set
                    if (!soft_flow_enable || !(tx_set1 || tx_set2)) begin
                        halt_sent <= 1'b0;
                    end else if (!halt_sent && rx_fifo_level >= halt_thr) begin
                        halt_sent <= 1'b1;
                        tx_is_halt <= 1'b1;
                        fc_tx_valid <= 1'b1;
                        fc_tx_data <= tx_set1 ? halt_char_one : halt_char_two;
                        tx_state <= UFC_TX_FIRST;
                    end else if (halt_sent && rx_fifo_level <= resume_thr) begin
                        // resume one first in double mode
                        halt_sent <= 1'b0;
                        tx_is_halt <= 1'b0;
                        fc_tx_valid <= 1'b1;
                        fc_tx_data <= tx_set1 ? resume_char_one : resume_char_two;
                        tx_state <= UFC_TX_FIRST;
                    end
                end
                UFC_TX_FIRST: begin
                    if (fc_tx_ready) begin
                        if (tx_set1 && tx_set2) begin
                            fc_tx_data <= tx_is_halt ? halt_char_two : resume_char_two;
                            tx_state <= UFC_TX_SECOND;
                        end else begin
                            fc_tx_valid <= 1'b0;
                            tx_state <= UFC_TX_IDLE;
                        end
                    end
                end
                UFC_TX_SECOND: begin
                    if (fc_tx_ready) begin
                        fc_tx_valid <= 1'b0;
                        tx_state <= UFC_TX_IDLE;
                    end
                end
                default: begin
                    fc_tx_valid <= 1'b0;
                    tx_state <= UFC_TX_IDLE;
                end
            endcase
        end
    end

    // Staging buffer between receiver and host side
    ufc_fifo #(.WIDTH(`UFC_BUF_WIDTH), .DEPTH(`UFC_BUF_DEPTH)) u_buf (
        .clk_sys(clk_sys),
        .srst(srst),
        .wr(buf_in),
        .rd(buf_out),
        .level()
    );

    assign buf_valid = buf_out.valid;
    assign buf_data = buf_out.data;
    assign buf_out.ready = buf_ready;
endmodule

// ### ufc_top_sva.sv
// Port checker of the flow control block
`timescale 1ns/1ps
module ufc_top_sva (
    input logic clk_sys,
    input logic srst,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata,
    input logic [7:0] rx_fifo_level,
    input logic rx_valid,
    input logic rx_ready,
    input logic fc_tx_valid,
    input logic cts_n,
    input logic rts_n,
    input logic tx_stop,
    input logic special_hit
);
    logic [7:0] cfg; // Shadow of the flow config register
    logic [7:0] lvl; // Shadow of the flow level register
    always_ff @(posedge clk_sys) begin
        if (srst) cfg <= 8'h00;
        else if (reg_wr && reg_addr == 8'h13) cfg <= reg_wdata;
        if (srst) lvl <= 8'h00;
        else if (reg_wr && reg_addr == 8'h0f) lvl <= reg_wdata;
    end
    wire [7:0] halt_thr = {1'b0, lvl[3:0], 3'b000};
    wire [7:0] res_thr = {1'b0, lvl[7:4], 3'b000};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence read_cfg_s;
        reg_rd && reg_addr == 8'h13;
    endsequence
    sequence taken_s;
        rx_valid && rx_ready;
    endsequence
    chk_rts_halt_level: assert property (cfg[0] && rx_fifo_level >= halt_thr |=> rts_n)
        else $error("rts not raised at halt level");
    chk_rts_resume_level: assert property (cfg[0] && rx_fifo_level <= res_thr
        && rx_fifo_level < halt_thr |=> !rts_n)
        else $error("rts not lowered at resume level");
    chk_rts_off_idle: assert property (!cfg[0] |=> rts_n)
        else $error("rts low without auto rts");
    chk_cts_stops_tx: assert property (cfg[1] && cts_n |=> tx_stop)
        else $error("cts high did not stop transmitter");
    chk_cfg_readback: assert property (read_cfg_s |=> reg_rdata == $past(cfg))
        else $error("config readback wrong");
    chk_unmapped_zero: assert property (reg_rd && reg_addr > 8'h17 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_no_soft_flow: assert property (!cfg[3] && !fc_tx_valid |=> !fc_tx_valid)
        else $error("flow char with soft flow off");
    chk_hit_cause: assert property (special_hit |-> $past(rx_valid && rx_ready))
        else $error("special hit without taken byte");
    chk_zero_no_hit: assert property (cfg[7:4] == 4'h0 ##0 taken_s |=> !special_hit)
        else $error("special hit with select zero");
endmodule
bind ufc_top ufc_top_sva chk (.*);
